// ==== hdl/isr_status_abort.sv ====
// Notes on behaviour
// - Slave busy bit is high whenever slave state machine is not idle.
// - Master busy bit is high whenever master state machine is not idle.
// - Receive full bit set when all receive locations occupied, else clear.
// - Receive has-data bit set while receive FIFO holds at least one entry.
// - Transmit empty bit set with no entries; resets to one; never interrupts.
// - Transmit has-room bit set while a location is free; resets to one.
// - Six-bit transmit entry count, read only, resets to zero.
// - Six-bit receive entry count, read only, resets to zero.
// - Read command written while answering a remote read flags slave read abort.
// - Slave losing bus while transmitting sets slave and general arbitration causes.
// - Slave transmitter compares SDA with intended bit at each SCL rise.
// - Read request as slave with stale transmit data: flag, interrupt, flush.
// - Arbitration-lost cause set by master loss or with slave cause.
// - Master start with master mode off sets cause and is refused.
// - Ten-bit master read with restart disabled sets dedicated cause.
// - Data byte not acknowledged after acknowledged address sets cause.
// - First ten-bit address byte not acknowledged sets cause.
`timescale 1ns/1ps
`default_nettype none
module isr_status_abort
	import isr_pkg::*;
#(
	parameter int FIFO_DEPTH = ISR_FIFO_DEPTH,
	parameter int CNT_W = ISR_CNT_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [ISR_AW-1:0] reg_addr,
	input wire logic [ISR_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ISR_DW-1:0] reg_rdata,
	output logic irq,
	// State machine activity
	input wire logic master_fsm_idle,
	input wire logic slave_fsm_idle,
	// FIFO occupancy events
	input wire logic tx_push,
	input wire logic tx_pop,
	input wire logic rx_push,
	input wire logic rx_pop,
	output logic tx_fifo_has_room,
	output logic rx_fifo_has_room,
	output logic tx_fifo_flush,
	// Controller events
	input wire logic master_mode_enable,
	input wire logic restart_generation_enable,
	input wire logic tenbit_addr_mode,
	input wire logic master_start_req,
	output logic master_start_grant,
	input wire logic master_read_cmd,
	input wire logic master_arbitration_lost_abort,
	input wire logic master_data_nack,
	input wire logic master_addr1_nack,
	input wire logic slave_read_req,
	input wire logic slave_read_pending,
	input wire logic data_command_port_wr,
	input wire logic data_command_port_cmd,
	input wire logic slave_tx_active,
	input wire logic abort_cause_clear,
	output logic transmit_abort_interrupt,
	// Serial line
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic tx_bit,
	input wire logic tx_drive,
	output logic sda_out,
	output logic sda_oe
);

	logic [CNT_W-1:0] tx_fifo_count;
	logic [CNT_W-1:0] rx_fifo_count;
	logic [15:0] data_hold_cycles;
	logic [15:0] abort_cause;
	logic [15:0] hold_cnt;
	logic [ISR_IRQ_NBITS-1:0] irq_stat;
	logic [ISR_IRQ_NBITS-1:0] irq_mask;
	logic [ISR_IRQ_NBITS-1:0] irq_event;
	logic [15:0] abort_event;
	logic [15:0] status_word;
	logic slave_fsm_busy;
	logic master_fsm_busy;
	logic rx_fifo_full_flag;
	logic rx_fifo_has_data;
	logic tx_fifo_empty_flag;
	logic scl_s1, scl_s2, scl_prev;
	logic sda_s1, sda_s2;
	logic scl_fall, scl_rise;
	logic slave_arbitration_abort;
	logic slave_stale_flush_abort;
	logic rx_full_prev;
	logic wr_irq_stat;

	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(FIFO_DEPTH);

	// Status flags
	assign slave_fsm_busy = ~slave_fsm_idle;
	assign master_fsm_busy = ~master_fsm_idle;
	assign rx_fifo_full_flag = (rx_fifo_count == FULL_COUNT);
	assign rx_fifo_has_data = (rx_fifo_count != '0);
	assign tx_fifo_empty_flag = (tx_fifo_count == '0);
	assign tx_fifo_has_room = (tx_fifo_count != FULL_COUNT);
	assign rx_fifo_has_room = ~rx_fifo_full_flag;

	always_comb begin
		status_word = '0;
		status_word[ISR_ST_SLV_BUSY] = slave_fsm_busy;
		status_word[ISR_ST_MST_BUSY] = master_fsm_busy;
		status_word[ISR_ST_RX_FULL] = rx_fifo_full_flag;
		status_word[ISR_ST_RX_DATA] = rx_fifo_has_data;
		status_word[ISR_ST_TX_EMPTY] = tx_fifo_empty_flag;
		status_word[ISR_ST_TX_ROOM] = tx_fifo_has_room;
		status_word[ISR_ST_ACTIVITY] = master_fsm_busy | slave_fsm_busy;
	end

	// Stale data is discarded when a remote read arrives
	assign slave_stale_flush_abort = slave_read_req & ~tx_fifo_empty_flag;
	assign tx_fifo_flush = slave_stale_flush_abort;

	// Transmit count; a flush outranks a same-cycle push
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_fifo_count <= '0;
		end else if (slave_stale_flush_abort) begin
			tx_fifo_count <= '0;
		end else begin
			case ({tx_push & tx_fifo_has_room, tx_pop & ~tx_fifo_empty_flag})
				2'b10: tx_fifo_count <= tx_fifo_count + 1'b1;
				2'b01: tx_fifo_count <= tx_fifo_count - 1'b1;
				default: tx_fifo_count <= tx_fifo_count;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_fifo_count <= '0;
		end else begin
			case ({rx_push & ~rx_fifo_full_flag, rx_pop & rx_fifo_has_data})
				2'b10: rx_fifo_count <= rx_fifo_count + 1'b1;
				2'b01: rx_fifo_count <= rx_fifo_count - 1'b1;
				default: rx_fifo_count <= rx_fifo_count;
			endcase
		end
	end

	// Pin synchronisers; first stage read only by second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_prev <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_prev <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
		end
	end

	assign scl_fall = scl_prev & ~scl_s2;
	assign scl_rise = ~scl_prev & scl_s2;

	// SDA only changes once the hold count after SCL falls expires
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= '0;
		end else if (scl_fall) begin
			hold_cnt <= (data_hold_cycles == '0) ? 16'h0001 : data_hold_cycles;
		end else if (hold_cnt != '0) begin
			hold_cnt <= hold_cnt - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe <= 1'b0;
		end else if (hold_cnt == 16'h0001) begin
			sda_oe <= tx_drive & ~tx_bit;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	// Released line must read high at SCL rise, else bus was lost
	assign slave_arbitration_abort = slave_tx_active & scl_rise & (sda_s2 != ~sda_oe);

	assign master_start_grant = master_start_req & master_mode_enable;

	always_comb begin
		abort_event = '0;
		abort_event[ISR_AB_SLV_RDCMD] = slave_read_pending & data_command_port_wr
			& data_command_port_cmd;
		abort_event[ISR_AB_SLV_ARB] = slave_arbitration_abort;
		abort_event[ISR_AB_SLV_FLUSH] = slave_stale_flush_abort;
		abort_event[ISR_AB_ARBITRATION_LOST_ABORT] = master_arbitration_lost_abort | slave_arbitration_abort;
		abort_event[ISR_AB_MASTER_OFF] = master_start_req & ~master_mode_enable;
		abort_event[ISR_AB_TENBIT_NORST] = master_read_cmd & tenbit_addr_mode
			& ~restart_generation_enable;
		abort_event[ISR_AB_DATA_NACK] = master_data_nack;
		abort_event[ISR_AB_ADDR1_NACK] = master_addr1_nack & tenbit_addr_mode;
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_cause <= ISR_ABORT_RESET;
		end else if (abort_cause_clear) begin
			abort_cause <= abort_event;
		end else begin
			abort_cause <= abort_cause | abort_event;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_abort_interrupt <= 1'b0;
		end else begin
			transmit_abort_interrupt <= |abort_event;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_hold_cycles <= ISR_HOLD_RESET;
		end else if (reg_wr && reg_addr == ISR_ADDR_HOLD) begin
			data_hold_cycles <= reg_wdata;
		end
	end

	// Transmit-empty is deliberately not an interrupt source
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_prev <= 1'b0;
		end else begin
			rx_full_prev <= rx_fifo_full_flag;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[ISR_IRQ_ABORT] = |abort_event;
		irq_event[ISR_IRQ_RX_FULL] = rx_fifo_full_flag & ~rx_full_prev;
		irq_event[ISR_IRQ_SLV_ARB] = slave_arbitration_abort;
	end

	assign wr_irq_stat = reg_wr && reg_addr == ISR_ADDR_IRQ_STAT;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
		end else if (wr_irq_stat) begin
			irq_stat <= (irq_stat & ~reg_wdata[ISR_IRQ_NBITS-1:0]) | irq_event;
		end else begin
			irq_stat <= irq_stat | irq_event;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= ISR_IRQ_MASK_RESET;
		end else if (reg_wr && reg_addr == ISR_ADDR_IRQ_MASK) begin
			irq_mask <= reg_wdata[ISR_IRQ_NBITS-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Read data valid the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (reg_addr == ISR_ADDR_STATUS) begin
			reg_rdata <= status_word;
		end else if (reg_addr == ISR_ADDR_TX_FIFO_COUNT) begin
			reg_rdata <= 16'(tx_fifo_count);
		end else if (reg_addr == ISR_ADDR_RX_FIFO_COUNT) begin
			reg_rdata <= 16'(rx_fifo_count);
		end else if (reg_addr == ISR_ADDR_HOLD) begin
			reg_rdata <= data_hold_cycles;
		end else if (reg_addr == ISR_ADDR_ABORT) begin
			reg_rdata <= abort_cause;
		end else if (reg_addr == ISR_ADDR_IRQ_STAT) begin
			reg_rdata <= 16'(irq_stat);
		end else if (reg_addr == ISR_ADDR_IRQ_MASK) begin
			reg_rdata <= 16'(irq_mask);
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule
`default_nettype wire

// ==== inc/isr_pkg.sv ====
package isr_pkg;

	localparam int ISR_AW = 32;
	localparam int ISR_DW = 16;

	localparam logic [31:0] ISR_ADDR_STATUS = 32'h5000_1370;
	localparam logic [31:0] ISR_ADDR_TX_FIFO_COUNT = 32'h5000_1374;
	localparam logic [31:0] ISR_ADDR_RX_FIFO_COUNT = 32'h5000_1378;
	localparam logic [31:0] ISR_ADDR_HOLD = 32'h5000_137C;
	localparam logic [31:0] ISR_ADDR_ABORT = 32'h5000_1380;
	localparam logic [31:0] ISR_ADDR_IRQ_STAT = 32'h5000_1384;
	localparam logic [31:0] ISR_ADDR_IRQ_MASK = 32'h5000_1388;

	// controller_status bit positions
	localparam int ISR_ST_ACTIVITY = 0;
	localparam int ISR_ST_TX_ROOM = 1;
	localparam int ISR_ST_TX_EMPTY = 2;
	localparam int ISR_ST_RX_DATA = 3;
	localparam int ISR_ST_RX_FULL = 4;
	localparam int ISR_ST_MST_BUSY = 5;
	localparam int ISR_ST_SLV_BUSY = 6;

	// transmit_abort_cause bit positions
	localparam int ISR_AB_ADDR1_NACK = 1;
	localparam int ISR_AB_DATA_NACK = 3;
	localparam int ISR_AB_TENBIT_NORST = 10;
	localparam int ISR_AB_MASTER_OFF = 11;
	localparam int ISR_AB_ARBITRATION_LOST_ABORT = 12;
	localparam int ISR_AB_SLV_FLUSH = 13;
	localparam int ISR_AB_SLV_ARB = 14;
	localparam int ISR_AB_SLV_RDCMD = 15;

	// Interrupt status / mask bit positions
	localparam int ISR_IRQ_NBITS = 3;
	localparam int ISR_IRQ_ABORT = 0;
	localparam int ISR_IRQ_RX_FULL = 1;
	localparam int ISR_IRQ_SLV_ARB = 2;

	localparam logic [15:0] ISR_HOLD_RESET = 16'h0001;
	localparam logic [15:0] ISR_ABORT_RESET = 16'h0000;
	localparam logic [ISR_IRQ_NBITS-1:0] ISR_IRQ_MASK_RESET = 3'h0;

	localparam int ISR_FIFO_DEPTH = 32;
	localparam int ISR_CNT_W = 6;

endpackage

// ==== bench/isr_bus_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module isr_bus_partner (
	input wire logic sys_clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic scl_drv = 1'b1;
	logic sda_drv = 1'b1;
	// Pull-up on both lines: a released line reads high
	assign scl = scl_drv;
	assign sda = sda_drv & ~sda_oe;
	task automatic drive(input logic c, input logic d);
		@(posedge sys_clk);
		scl_drv <= c;
		sda_drv <= d;
	endtask
endmodule
`default_nettype wire

// ==== bench/isr_status_abort_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module isr_status_abort_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic tx_push,
	input wire logic tx_fifo_has_room,
	input wire logic rx_push,
	input wire logic rx_fifo_has_room,
	input wire logic tx_fifo_flush,
	input wire logic master_start_req,
	input wire logic master_mode_enable,
	input wire logic master_start_grant,
	input wire logic master_read_cmd,
	input wire logic tenbit_addr_mode,
	input wire logic restart_generation_enable,
	input wire logic master_arbitration_lost_abort,
	input wire logic master_data_nack,
	input wire logic master_addr1_nack,
	input wire logic slave_read_pending,
	input wire logic data_command_port_wr,
	input wire logic data_command_port_cmd,
	input wire logic transmit_abort_interrupt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence abort_next;
		##1 transmit_abort_interrupt;
	endsequence
	flush_abort_a: assert property (tx_fifo_flush |-> abort_next)
		else $error("flush without abort pulse");
	master_off_a: assert property (master_start_req && !master_mode_enable |->
		!master_start_grant ##0 abort_next) else $error("start not refused");
	grant_pass_a: assert property (master_start_req && master_mode_enable |-> master_start_grant)
		else $error("start not granted");
	tenbit_read_a: assert property (master_read_cmd && tenbit_addr_mode
		&& !restart_generation_enable |-> abort_next) else $error("ten-bit read missed");
	arbitration_lost_abort_a: assert property (master_arbitration_lost_abort |-> abort_next)
		else $error("arbitration loss missed");
	data_nack_a: assert property (master_data_nack |-> abort_next)
		else $error("data nack missed");
	addr_nack_a: assert property (master_addr1_nack && tenbit_addr_mode |-> abort_next)
		else $error("address nack missed");
	slave_rdcmd_a: assert property (slave_read_pending && data_command_port_wr
		&& data_command_port_cmd |-> abort_next) else $error("slave read command missed");
	tx_full_a: assert property ($fell(tx_fifo_has_room) |-> $past(tx_push))
		else $error("room lost without push");
	rx_full_a: assert property ($fell(rx_fifo_has_room) |-> $past(rx_push))
		else $error("receive room lost without push");
endmodule
bind isr_status_abort isr_status_abort_monitor isr_status_abort_monitor_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .tx_push(tx_push), .tx_fifo_has_room(tx_fifo_has_room),
	.rx_push(rx_push), .rx_fifo_has_room(rx_fifo_has_room),
	.tx_fifo_flush(tx_fifo_flush), .master_start_req(master_start_req),
	.master_mode_enable(master_mode_enable), .master_start_grant(master_start_grant),
	.master_read_cmd(master_read_cmd), .tenbit_addr_mode(tenbit_addr_mode),
	.restart_generation_enable(restart_generation_enable), .master_arbitration_lost_abort(master_arbitration_lost_abort),
	.master_data_nack(master_data_nack), .master_addr1_nack(master_addr1_nack),
	.slave_read_pending(slave_read_pending), .data_command_port_wr(data_command_port_wr),
	.data_command_port_cmd(data_command_port_cmd),
	.transmit_abort_interrupt(transmit_abort_interrupt));
`default_nettype wire

// ==== bench/isr_status_abort_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module isr_status_abort_tb
	import isr_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [11:0] ev = 12'h000;
	logic [9:0] lv = 10'h00F;
	wire logic [15:0] reg_rdata;
	wire logic irq, sda_oe, scl, sda;
	int errors = 0;
	int n_compared = 0;
	logic [31:0] ra [6] = '{ISR_ADDR_STATUS, ISR_ADDR_TX_FIFO_COUNT, ISR_ADDR_RX_FIFO_COUNT, ISR_ADDR_HOLD,
		ISR_ADDR_ABORT, 32'h5000_1390};
	logic [15:0] rv [6] = '{16'h0006, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
	logic [15:0] ab [6] = '{16'h0800, 16'h0400, 16'h1000, 16'h0008, 16'h0002, 16'h8000};
	isr_status_abort isr_status_abort_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .master_fsm_idle(lv[0]), .slave_fsm_idle(lv[1]),
		.tx_push(ev[7]), .tx_pop(ev[8]), .rx_push(ev[9]), .rx_pop(ev[10]),
		.tx_fifo_has_room(), .rx_fifo_has_room(), .tx_fifo_flush(),
		.master_mode_enable(lv[2]), .restart_generation_enable(lv[3]),
		.tenbit_addr_mode(lv[4]), .master_start_req(ev[0]), .master_start_grant(),
		.master_read_cmd(ev[1]), .master_arbitration_lost_abort(ev[2]), .master_data_nack(ev[3]),
		.master_addr1_nack(ev[4]), .slave_read_req(ev[6]), .slave_read_pending(lv[5]),
		.data_command_port_wr(ev[5]), .data_command_port_cmd(lv[6]),
		.slave_tx_active(lv[7]), .abort_cause_clear(ev[11]), .transmit_abort_interrupt(),
		.scl_in(scl), .sda_in(sda), .tx_bit(lv[8]), .tx_drive(lv[9]), .sda_out(), .sda_oe(sda_oe));
	isr_bus_partner p (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [15:0] e, input string nm);
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata);
	endtask
	task automatic fire(input int k);
		@(posedge sys_clk) ev <= 12'(1 << k);
		@(posedge sys_clk) ev <= 12'h000;
	endtask
	// Counts from the SCL fall at the pin until sda_oe reaches tgt
	task automatic hold_span(input logic tgt, output int n);
		p.drive(1'b1, 1'b1);
		repeat (8) @(posedge sys_clk);
		lv[9:8] <= {1'b1, ~tgt};
		p.drive(1'b0, 1'b1);
		n = 0;
		while (sda_oe !== tgt && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		print_verdict();
	end
	initial begin
		int n1;
		int n4;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], rv[i], "reset value");
		end
		wr(ISR_ADDR_STATUS, 16'hFFFF);
		rd(ISR_ADDR_STATUS, 16'h0006, "status after write");
		wr(ISR_ADDR_HOLD, 16'hA5C3);
		rd(ISR_ADDR_HOLD, 16'hA5C3, "hold");
		@(posedge sys_clk) lv <= 10'h00E;
		rd(ISR_ADDR_STATUS, 16'h0027, "master busy");
		@(posedge sys_clk) lv <= 10'h00D;
		rd(ISR_ADDR_STATUS, 16'h0047, "slave busy");
		@(posedge sys_clk) lv <= 10'h00F;
		repeat (33) fire(7);
		rd(ISR_ADDR_TX_FIFO_COUNT, 16'h0020, "tx count");
		rd(ISR_ADDR_STATUS, 16'h0000, "tx full");
		rd(ISR_ADDR_IRQ_STAT, 16'h0000, "no tx irq");
		fire(8);
		rd(ISR_ADDR_TX_FIFO_COUNT, 16'h001F, "tx pop");
		rd(ISR_ADDR_STATUS, 16'h0002, "tx room back");
		fire(6);
		rd(ISR_ADDR_TX_FIFO_COUNT, 16'h0000, "flushed");
		rd(ISR_ADDR_ABORT, 16'h2000, "flush cause");
		fire(11);
		repeat (32) fire(9);
		rd(ISR_ADDR_RX_FIFO_COUNT, 16'h0020, "rx count");
		rd(ISR_ADDR_STATUS, 16'h001E, "rx full");
		fire(10);
		rd(ISR_ADDR_RX_FIFO_COUNT, 16'h001F, "rx count");
		rd(ISR_ADDR_STATUS, 16'h000E, "rx room");
		@(posedge sys_clk) lv <= 10'h073;
		for (int k = 0; k < 6; k++) begin
			fire(k);
			rd(ISR_ADDR_ABORT, ab[k], "abort cause");
			fire(11);
		end
		@(posedge sys_clk) lv <= 10'h00F;
		fire(0);
		fire(1);
		fire(4);
		rd(ISR_ADDR_ABORT, 16'h0000, "no cause");
		rd(ISR_ADDR_IRQ_STAT, 16'h0003, "irq status");
		chk("irq masked", 16'h0000, {15'h0, irq});
		wr(ISR_ADDR_IRQ_MASK, 16'h0001);
		repeat (2) @(posedge sys_clk);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(ISR_ADDR_IRQ_STAT, 16'h0001);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 16'h0000, {15'h0, irq});
		@(posedge sys_clk) lv <= 10'h38F;
		p.drive(1'b0, 1'b0);
		repeat (4) @(posedge sys_clk);
		p.drive(1'b1, 1'b0);
		repeat (6) @(posedge sys_clk);
		rd(ISR_ADDR_ABORT, 16'h5000, "slave arbitration");
		@(posedge sys_clk) lv <= 10'h00F;
		fire(11);
		wr(ISR_ADDR_HOLD, 16'h0001);
		hold_span(1'b1, n1);
		wr(ISR_ADDR_HOLD, 16'h0004);
		hold_span(1'b0, n4);
		chk("hold span", 16'h0003, 16'(n4 - n1));
		print_verdict();
	end
endmodule
`default_nettype wire
